// ==== verilog/euart_cfg.svh ====
// How it works
// - Global enable bit seven gates every interrupt.
// - Transmit ready while transmit level below threshold.
// - Receive ready set when level exceeds threshold.
// - Receive ready also on idle timeout.
// - Receive ready clears on zero write below threshold.
// - Receive overflow on byte into full FIFO.
// - Receive underflow on data read while empty.
// - Framing error flag on missing stop bit.
// - Transmit complete when shifter and FIFO empty.
// - Read gives flags, write gives enables.
// - Data read pops oldest receive byte.
// - Data write pushes byte into transmit FIFO.
`ifndef EUART_CFG_SVH
`define EUART_CFG_SVH
`define A_CTRL      8'hB2
`define A_FIFO      8'hB3
`define A_IRQ       8'hB4
`define A_DATA      8'hB5
`define A_DIVL      8'hB6
`define A_DIVH      8'hB7
`define A_CLR       8'hB8
`define A_ENA       8'hB9
`define B_GEN       7
`define B_TRA       6
`define B_RDA       5
`define B_RFO       4
`define B_RFU       3
`define B_TFO       2
`define B_FRAMING_ERROR_FLAG      1
`define B_TI        0
`define B_CLRFIFO   1
`define RST_DIV     16'h0000
`define RST_THR     4'h0
`define RST_EN      7'h00
`define FIFO_DEPTH  4'hF
`define OVS_LAST    4'hF
`define OVS_MID     4'h7
`define RX_LAST_BIT 4'h7
`define TX_LAST_BIT 4'h9
`define IDLE_MAX    8'hFF
`endif

// ==== verilog/euart_pkg.sv ====
package euart_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
   typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;
   typedef struct packed {
      logic [14:0][7:0] mem;
      logic [3:0]       wr;
      logic [3:0]       rd;
      logic [3:0]       cnt;
   } fifo_s;
   typedef struct packed {
      logic      ack;
      byte_t     rdata;
      logic      gen;
      logic [6:0] en;
      logic [5:0] flg;
      logic [3:0] thr_rx;
      logic [3:0] thr_tx;
      logic [15:0] div;
      logic      clr;
      logic [15:0] baud_cnt;
      logic      tick;
      rx_state_e rx_st;
      logic [3:0] rx_cnt;
      logic [3:0] rx_bit;
      byte_t     rx_sh;
      logic [7:0] idle_cnt;
      tx_state_e tx_st;
      logic [3:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [9:0] tx_sh;
      logic      txd;
   } regs_s;
endpackage

// ==== verilog/euart_fifo.sv ====
`timescale 1ns/10ps
`include "euart_cfg.svh"
module euart_fifo
   import euart_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic         clr,
   input  wire logic         push,
   input  wire euart_pkg::byte_t din,
   input  wire logic         pop,
   output euart_pkg::byte_t  dout,
   output logic [3:0]        level,
   output logic              full,
   output logic              empty
);
   import euart_pkg::*;
   fifo_s s_q;
   fifo_s s_d;
   logic  do_push;
   logic  do_pop;

   assign full  = (s_q.cnt == `FIFO_DEPTH);
   assign empty = (s_q.cnt == 4'h0);
   assign level = s_q.cnt;
   assign dout  = s_q.mem[s_q.rd];

   // Pushes into a full FIFO and pops from an empty one are dropped here; the
   // register block turns them into overflow and underflow events.
   always_comb begin
      s_d     = s_q;
      do_push = push & ~full;
      do_pop  = pop & ~empty;
      if (do_push) begin
         s_d.mem[s_q.wr] = din;
         s_d.wr = (s_q.wr == `FIFO_DEPTH - 4'h1) ? 4'h0 : s_q.wr + 4'h1;
      end
      if (do_pop) begin
         s_d.rd = (s_q.rd == `FIFO_DEPTH - 4'h1) ? 4'h0 : s_q.rd + 4'h1;
      end
      s_d.cnt = s_q.cnt + {3'h0, do_push} - {3'h0, do_pop};
      if (clr) begin
         s_d.wr  = 4'h0;
         s_d.rd  = 4'h0;
         s_d.cnt = 4'h0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ==== verilog/euart_irq_data_baud_regs.sv ====
`timescale 1ns/10ps
`include "euart_cfg.svh"
module euart_irq_data_baud_regs
   import euart_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   input  wire logic        rxd,
   output logic             txd,
   output logic             irq
);
   import euart_pkg::*;
   regs_s       s_q;
   regs_s       s_d;
   logic        req;
   logic        acc;
   logic        done;
   logic        wr_ok;
   logic        tra;
   logic        idle_hit;
   logic [5:0]  ev;
   logic [5:0]  clr_m;
   logic        rx_push;
   logic        rx_pop;
   logic        tx_push;
   logic        tx_pop;
   byte_t       rx_dout;
   byte_t       tx_dout;
   logic [3:0]  rx_level;
   logic [3:0]  tx_level;
   logic        rx_full;
   logic        rx_empty;
   logic        tx_full;
   logic        tx_empty;

   euart_fifo u_rx_fifo (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clr     (s_q.clr),
      .push    (rx_push),
      .din     (s_q.rx_sh),
      .pop     (rx_pop),
      .dout    (rx_dout),
      .level   (rx_level),
      .full    (rx_full),
      .empty   (rx_empty)
   );

   euart_fifo u_tx_fifo (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clr     (s_q.clr),
      .push    (tx_push),
      .din     (writedata[7:0]),
      .pop     (tx_pop),
      .dout    (tx_dout),
      .level   (tx_level),
      .full    (tx_full),
      .empty   (tx_empty)
   );

   // Every access takes two edges: data is captured on the first, side
   // effects such as FIFO pops happen on the second, when waitrequest is low.
   assign req         = read | write;
   assign acc         = req & ~s_q.ack;
   assign done        = req & s_q.ack;
   assign wr_ok       = done & write & byteenable[0];
   assign waitrequest = req & ~s_q.ack;
   assign readdata    = {24'h000000, s_q.rdata};
   assign txd         = s_q.txd;
   assign tra         = (tx_level < s_q.thr_tx);
   assign idle_hit    = (rx_level < s_q.thr_rx) && (rx_level != 4'h0) &&
                        (s_q.idle_cnt > {s_q.thr_rx, 4'h0});
   assign irq         = s_q.gen & |({tra, s_q.flg} & s_q.en);

   always_comb begin
      s_d     = s_q;
      s_d.ack = acc;
      s_d.clr = 1'b0;
      ev      = 6'h00;
      clr_m   = 6'h00;
      rx_push = 1'b0;
      rx_pop  = 1'b0;
      tx_push = 1'b0;
      tx_pop  = 1'b0;

      if (acc && read) begin
         case (address)
            `A_IRQ:  s_d.rdata = {s_q.gen, tra, s_q.flg};
            `A_DATA: s_d.rdata = rx_empty ? 8'h00 : rx_dout;
            `A_DIVL: s_d.rdata = s_q.div[7:0];
            `A_DIVH: s_d.rdata = s_q.div[15:8];
            `A_FIFO: s_d.rdata = {rx_level, tx_level};
            `A_ENA:  s_d.rdata = {s_q.gen, s_q.en};
            default: s_d.rdata = 8'h00;
         endcase
      end

      if (done && read && address == `A_DATA) begin
         if (rx_empty) begin
            ev[`B_RFU] = 1'b1;
         end else begin
            rx_pop = 1'b1;
         end
      end

      if (wr_ok) begin
         case (address)
            `A_IRQ, `A_ENA: begin
               s_d.gen = writedata[`B_GEN];
               s_d.en  = writedata[6:0];
               clr_m   = ~writedata[5:0];
            end
            `A_DATA: begin
               if (tx_full) begin
                  ev[`B_TFO] = 1'b1;
               end else begin
                  tx_push = 1'b1;
               end
            end
            `A_DIVL: s_d.div[7:0]  = writedata[7:0];
            `A_DIVH: s_d.div[15:8] = writedata[7:0];
            `A_FIFO: begin
               s_d.thr_rx = writedata[7:4];
               s_d.thr_tx = writedata[3:0];
            end
            `A_CTRL: s_d.clr = writedata[`B_CLRFIFO];
            `A_CLR:  clr_m = writedata[5:0];
            default: s_d.ack = acc;
         endcase
      end

      // Sixteen ticks per bit; a divisor of zero holds the generator still.
      s_d.tick = 1'b0;
      if (s_q.div == 16'h0000) begin
         s_d.baud_cnt = 16'h0000;
      end else if (s_q.baud_cnt >= s_q.div - 16'h0001) begin
         s_d.baud_cnt = 16'h0000;
         s_d.tick     = 1'b1;
      end else begin
         s_d.baud_cnt = s_q.baud_cnt + 16'h0001;
      end

      if (s_q.tick) begin
         s_d.rx_cnt = s_q.rx_cnt + 4'h1;
         case (s_q.rx_st)
            RX_IDLE: begin
               if (!rxd) begin
                  s_d.rx_st    = RX_START;
                  s_d.rx_cnt   = 4'h0;
                  s_d.idle_cnt = 8'h00;
               end else if (s_q.rx_cnt == `OVS_LAST && s_q.idle_cnt != `IDLE_MAX) begin
                  s_d.idle_cnt = s_q.idle_cnt + 8'h01;
               end
            end
            RX_START: begin
               if (s_q.rx_cnt == `OVS_MID) begin
                  s_d.rx_cnt = 4'h0;
                  s_d.rx_bit = 4'h0;
                  s_d.rx_st  = rxd ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (s_q.rx_cnt == `OVS_LAST) begin
                  s_d.rx_sh  = {rxd, s_q.rx_sh[7:1]};
                  s_d.rx_bit = s_q.rx_bit + 4'h1;
                  if (s_q.rx_bit == `RX_LAST_BIT) begin
                     s_d.rx_st = RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (s_q.rx_cnt == `OVS_LAST) begin
                  if (rx_full) begin
                     ev[`B_RFO] = 1'b1;
                  end else begin
                     rx_push = 1'b1;
                  end
                  ev[`B_FRAMING_ERROR_FLAG] = ~rxd;
                  s_d.rx_st   = RX_IDLE;
                  s_d.rx_cnt  = 4'h0;
               end
            end
            default: s_d.rx_st = RX_IDLE;
         endcase
      end

      case (s_q.tx_st)
         TX_IDLE: begin
            if (!tx_empty) begin
               tx_pop     = 1'b1;
               s_d.tx_sh  = {1'b1, tx_dout, 1'b0};
               s_d.tx_cnt = 4'h0;
               s_d.tx_bit = 4'h0;
               s_d.tx_st  = TX_SHIFT;
            end
         end
         TX_SHIFT: begin
            if (s_q.tick) begin
               s_d.tx_cnt = s_q.tx_cnt + 4'h1;
               if (s_q.tx_cnt == `OVS_LAST) begin
                  s_d.tx_sh  = {1'b1, s_q.tx_sh[9:1]};
                  s_d.tx_bit = s_q.tx_bit + 4'h1;
                  if (s_q.tx_bit == `TX_LAST_BIT) begin
                     s_d.tx_st  = TX_IDLE;
                     ev[`B_TI]  = tx_empty;
                  end
               end
            end
         end
         default: s_d.tx_st = TX_IDLE;
      endcase
      s_d.txd = (s_d.tx_st == TX_SHIFT) ? s_d.tx_sh[0] : 1'b1;

      ev[`B_RDA] = (rx_level > s_q.thr_rx) | idle_hit;
      // Receive ready may only be dropped once the FIFO has drained below
      // its threshold, so software cannot lose sight of pending bytes.
      if (rx_level >= s_q.thr_rx) begin
         clr_m[`B_RDA] = 1'b0;
      end
      if (s_q.clr) begin
         clr_m[`B_RFO] = 1'b1;
         clr_m[`B_RFU] = 1'b1;
         clr_m[`B_TFO] = 1'b1;
      end
      // A new event wins over a clear in the same cycle.
      s_d.flg = (s_q.flg & ~clr_m) | ev;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q        <= '0;
         s_q.gen    <= 1'b0;
         s_q.en     <= `RST_EN;
         s_q.div    <= `RST_DIV;
         s_q.thr_rx <= `RST_THR;
         s_q.thr_tx <= `RST_THR;
         s_q.rx_st  <= RX_IDLE;
         s_q.tx_st  <= TX_IDLE;
         s_q.txd    <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   AST_IRQ_GATED: assert property (@(posedge ref_clk) disable iff (rst)
      irq |-> (s_q.gen && ({tra, s_q.flg} & s_q.en) != 7'h00))
      else $error("Interrupt raised without global and event enable.");

   AST_TRA_LEVEL: assert property (@(posedge ref_clk) disable iff (rst)
      (s_q.gen && s_q.en[6] && tx_level < s_q.thr_tx) |-> irq)
      else $error("Transmit ready did not raise the interrupt.");

   AST_RDA_SET: assert property (@(posedge ref_clk) disable iff (rst)
      (rx_level > s_q.thr_rx) |=> s_q.flg[`B_RDA])
      else $error("Receive ready not set above threshold.");

   AST_RDA_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
      (s_q.flg[`B_RDA] && rx_level >= s_q.thr_rx) |=> s_q.flg[`B_RDA])
      else $error("Receive ready dropped at or above threshold.");

   AST_RFO_SET: assert property (@(posedge ref_clk) disable iff (rst)
      (s_q.tick && s_q.rx_st == RX_STOP && s_q.rx_cnt == `OVS_LAST && rx_full)
      |=> s_q.flg[`B_RFO])
      else $error("Receive overflow not flagged.");

   AST_RFU_SET: assert property (@(posedge ref_clk) disable iff (rst)
      (done && read && address == `A_DATA && rx_empty) |=> s_q.flg[`B_RFU])
      else $error("Receive underflow not flagged.");

   AST_TFO_SET: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_ok && address == `A_DATA && tx_full) |=> s_q.flg[`B_TFO])
      else $error("Transmit overflow not flagged.");

   AST_EN_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_ok && address == `A_IRQ) |=> (s_q.en == $past(writedata[6:0])))
      else $error("Interrupt write did not load the enables.");

   AST_ONE_WAIT: assert property (@(posedge ref_clk) disable iff (rst)
      (req && waitrequest) |=> !waitrequest)
      else $error("Bus access held for more than one wait cycle.");

   // The clear checks leave out cycles in which a new event may win over the clear.
   AST_GEN_OFF: assert property (@(posedge ref_clk) disable iff (rst)
      !s_q.gen |-> !irq)
      else $error("Interrupt raised while globally disabled.");

   AST_TRA_READ: assert property (@(posedge ref_clk) disable iff (rst)
      (acc && read && address == `A_IRQ) |=> (s_q.rdata[`B_TRA] == $past(tra)))
      else $error("Transmit ready read back wrong.");

   AST_RDA_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
      (rx_level != 4'h0 && rx_level < s_q.thr_rx && s_q.idle_cnt > {s_q.thr_rx, 4'h0})
      |=> s_q.flg[`B_RDA])
      else $error("Receive ready not set after idle timeout.");

   AST_RFO_CLR: assert property (@(posedge ref_clk) disable iff (rst)
      (s_q.clr && !s_q.tick) |=> !s_q.flg[`B_RFO])
      else $error("FIFO reset left receive overflow set.");

   AST_RFU_CLR: assert property (@(posedge ref_clk) disable iff (rst)
      (s_q.clr && !(done && read && address == `A_DATA)) |=> !s_q.flg[`B_RFU])
      else $error("FIFO reset left receive underflow set.");

   AST_TFO_CLR: assert property (@(posedge ref_clk) disable iff (rst)
      (s_q.clr && !(wr_ok && address == `A_DATA)) |=> !s_q.flg[`B_TFO])
      else $error("FIFO reset left transmit overflow set.");

   AST_FRAMING_ERROR_FLAG_SET: assert property (@(posedge ref_clk) disable iff (rst)
      (s_q.tick && s_q.rx_st == RX_STOP && s_q.rx_cnt == `OVS_LAST && !rxd)
      |=> s_q.flg[`B_FRAMING_ERROR_FLAG])
      else $error("Framing error not flagged.");

   AST_TI_SET: assert property (@(posedge ref_clk) disable iff (rst)
      (s_q.tick && s_q.tx_st == TX_SHIFT && s_q.tx_cnt == `OVS_LAST &&
       s_q.tx_bit == `TX_LAST_BIT && tx_empty) |=> s_q.flg[`B_TI])
      else $error("Transmit complete not flagged.");

   AST_ZERO_CLR: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_ok && address == `A_IRQ && !writedata[`B_FRAMING_ERROR_FLAG] && !s_q.tick)
      |=> (!s_q.flg[`B_FRAMING_ERROR_FLAG] && !s_q.en[`B_FRAMING_ERROR_FLAG]))
      else $error("Zero write did not clear flag and enable.");

   AST_POP: assert property (@(posedge ref_clk) disable iff (rst)
      (done && read && address == `A_DATA && !rx_empty && !rx_push && !s_q.clr)
      |=> (rx_level == $past(rx_level) - 4'h1))
      else $error("Data read did not pop the receive FIFO.");

   AST_PUSH: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_ok && address == `A_DATA && !tx_full && !tx_pop && !s_q.clr)
      |=> (tx_level == $past(tx_level) + 4'h1))
      else $error("Data write did not push the transmit FIFO.");

   AST_TICK: assert property (@(posedge ref_clk) disable iff (rst)
      (s_q.div != 16'h0000 && s_q.baud_cnt == s_q.div - 16'h0001) |=> s_q.tick)
      else $error("Baud tick missing at divisor end.");

   AST_TICK_STOP: assert property (@(posedge ref_clk) disable iff (rst)
      (s_q.div == `RST_DIV) |=> !s_q.tick)
      else $error("Baud tick with a zero divisor.");
endmodule

// ==== verif/uart_peer.sv ====
`timescale 1ns/10ps
module uart_peer #(
   parameter int BIT_CLKS = 32
) (
   input  wire logic       ref_clk,
   input  wire logic       txd,
   output logic            rxd,
   output logic            got,
   output logic [7:0]      got_byte
);
   logic [7:0] sh;
   logic [9:0] fr;

   initial begin
      rxd = 1'b1;
      got = 1'b0;
      got_byte = 8'h00;
   end

   // A bad stop bit is cut short, so the line is high again before any false start is rechecked.
   task automatic send(input logic [7:0] b, input logic stop);
      fr = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= fr[i];
         repeat ((i == 9 && !stop) ? BIT_CLKS * 5 / 8 : BIT_CLKS) @(posedge ref_clk);
      end
      if (!stop) begin
         rxd <= 1'b1;
         repeat (BIT_CLKS * 3 / 8) @(posedge ref_clk);
      end
   endtask

   // Samples in mid bit; a missing stop bit hands on the inverted byte.
   always begin
      @(negedge txd);
      repeat (BIT_CLKS / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge ref_clk);
         sh[i] = txd;
      end
      repeat (BIT_CLKS) @(posedge ref_clk);
      got_byte <= (txd === 1'b1) ? sh : ~sh;
      got <= 1'b1;
      @(posedge ref_clk);
      got <= 1'b0;
   end
endmodule

// ==== verif/tb_euart_irq_data_baud_regs.sv ====
`timescale 1ns/10ps
`include "euart_cfg.svh"
module tb_euart_irq_data_baud_regs;
   localparam logic [7:0] DIV_LO = 8'h02;
   logic        ref_clk = 1'b0;
   logic        rst;
   logic [7:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [3:0]  byteenable;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        rxd;
   logic        txd;
   logic        irq;
   logic        got;
   logic [7:0]  got_byte;
   logic [7:0]  d;
   logic [7:0]  b [3];
   logic [7:0]  exp_q [$];
   logic [7:0]  tx_q [$];
   int          error_cnt = 0;
   int          check_count = 0;
   integer      seed;

   always #5 ref_clk = ~ref_clk;

   euart_irq_data_baud_regs i_euart_irq_data_baud_regs (
      .ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .rxd(rxd), .txd(txd), .irq(irq));

   uart_peer #(.BIT_CLKS(16 * DIV_LO)) i_uart_peer (
      .ref_clk(ref_clk), .txd(txd), .rxd(rxd), .got(got), .got_byte(got_byte));

   task automatic check(input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value at %0t: saw %h expected %h", $time, s, e);
      end
   endtask

   task automatic stop_test();
      // An expectation that was never answered is a mismatch as well.
      if (exp_q.size() != 0 || tx_q.size() != 0)
         error_cnt++;
      if (error_cnt == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // One idle cycle after each access keeps a release and the next request apart.
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] v);
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= {24'h000000, v};
      if (!wr)
         exp_q.push_back(v);
      do begin
         @(posedge ref_clk);
      end while (waitrequest !== 1'b0);
      read <= 1'b0;
      write <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      acc(1'b1, a, v);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, e);
   endtask

   task automatic drain();
      for (int n = 0; n < 12000 && tx_q.size() != 0; n++)
         @(posedge ref_clk);
      repeat (40) @(posedge ref_clk);
   endtask

   always @(posedge ref_clk) begin
      if (read && !waitrequest && exp_q.size() > 0)
         check(readdata[7:0], exp_q.pop_front());
      if (got)
         check(got_byte, (tx_q.size() > 0) ? tx_q.pop_front() : ~got_byte);
   end

   initial begin
      repeat (60000) @(posedge ref_clk);
      error_cnt++;
      stop_test();
   end

   initial begin
      seed = 96;
      rst = 1'b1;
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h00000000;
      byteenable = 4'hF;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(`A_IRQ, 8'h00);
      check({7'h00, irq}, 8'h00);
      rd(8'hB0, 8'h00);
      rd(`A_DIVL, 8'h00);
      d = 8'($random(seed));
      wr(`A_DIVH, d);
      rd(`A_DIVH, d);
      wr(`A_DIVH, 8'h00);
      wr(`A_DIVL, DIV_LO);
      byteenable <= 4'h0;
      wr(`A_DIVL, 8'h07);
      byteenable <= 4'hF;
      rd(`A_DIVL, DIV_LO);
      wr(`A_FIFO, 8'h21);
      rd(`A_IRQ, 8'h40);
      for (int i = 0; i < 2; i++) begin
         d = 8'($random(seed));
         tx_q.push_back(d);
         wr(`A_DATA, d);
      end
      rd(`A_IRQ, 8'h00);
      drain();
      rd(`A_IRQ, 8'h41);
      wr(`A_IRQ, 8'h81);
      check({7'h00, irq}, 8'h01);
      wr(`A_IRQ, 8'h01);
      check({7'h00, irq}, 8'h00);
      wr(`A_IRQ, 8'h80);
      rd(`A_IRQ, 8'hC0);
      for (int i = 0; i < 3; i++) begin
         b[i] = 8'($random(seed));
         i_uart_peer.send(b[i], 1'b1);
      end
      rd(`A_IRQ, 8'hE0);
      wr(`A_IRQ, 8'h80);
      rd(`A_IRQ, 8'hE0);
      for (int i = 0; i < 3; i++)
         rd(`A_DATA, b[i]);
      rd(`A_DATA, 8'h00);
      rd(`A_IRQ, 8'hE8);
      wr(`A_IRQ, 8'h88);
      check({7'h00, irq}, 8'h01);
      rd(`A_ENA, 8'h88);
      rd(`A_IRQ, 8'hC8);
      wr(`A_CLR, 8'h08);
      rd(`A_IRQ, 8'hC0);
      d = 8'($random(seed));
      i_uart_peer.send(d, 1'b0);
      rd(`A_IRQ, 8'hC2);
      repeat (45 * 16 * DIV_LO) @(posedge ref_clk);
      rd(`A_IRQ, 8'hE2);
      rd(`A_DATA, d);
      wr(`A_IRQ, 8'h80);
      rd(`A_IRQ, 8'hC0);
      for (int i = 0; i < 16; i++)
         i_uart_peer.send(8'($random(seed)), 1'b1);
      rd(`A_IRQ, 8'hF0);
      wr(`A_CTRL, 8'h02);
      rd(`A_FIFO, 8'h00);
      rd(`A_IRQ, 8'hE0);
      wr(`A_IRQ, 8'h80);
      for (int i = 0; i < 17; i++) begin
         d = 8'($random(seed));
         if (i < 16)
            tx_q.push_back(d);
         wr(`A_DATA, d);
      end
      rd(`A_IRQ, 8'h84);
      drain();
      rd(`A_IRQ, 8'hC5);
      wr(`A_CTRL, 8'h02);
      rd(`A_IRQ, 8'hC1);
      stop_test();
   end
endmodule
